// ### inc/flash_map_consts.svh
// constants for the flash map and protect control block
// assumes: included by both ends, the monitor and the bench
`ifndef FLASH_MAP_CONSTS_SVH
`define FLASH_MAP_CONSTS_SVH
// register addresses in the cpu space
`define ADDR_CTRL_SHADOW   16'h0FD0
`define ADDR_CTRL_COMMIT   16'h0FD1
`define ADDR_SLEEP_REG     16'h0FD2
`define ADDR_PROM_PORT     16'h0FD3
`define ADDR_SYS_CTRL_3    16'h0FD4
`define ADDR_SYS_COMMIT    16'h0FD5
// keys and codes
`define COMMIT_KEY         8'hD5
`define SYS_COMMIT_KEY     8'hD4
`define PROTECT_ENABLE     3'b101
`define PROTECT_DISABLE    3'b010
`define AREA_STANDARD      2'b00
`define AREA_CODE_TO_DATA  2'b10
// field positions in the shadow, system control and prom port registers
`define PROTECT_MSB        6
`define PROTECT_LSB        4
`define BOOT_SHOW_BIT      3
`define AREA_MSB           2
`define AREA_LSB           1
`define RAM_REMAP_BIT      0
`define VECTOR_RAM_BIT     1
`define SERIAL_CLK_EN_BIT  1
`define OTHER_PORT_EN_BIT  0
// reset values
`define SHADOW_RESET       8'h20
`define PROM_PORT_RESET    8'h80
// address windows
`define FLASH_LO           16'h8000
`define BOOT_LO            16'h1000
`define BOOT_DATA_HI       16'h17FF
`define BOOT_CODE_HI_PROM  16'h1FFF
`endif

// ### inc/flash_map_pkg.sv
// types for the flash map and protect control block
// assumes: nothing beyond the constants header
package flash_map_pkg;
  // target of a resolved cpu access
  typedef enum logic [1:0] {
    TGT_FLASH = 2'b00,
    TGT_BOOT  = 2'b01,
    TGT_RAM   = 2'b11,
    TGT_OTHER = 2'b10
  } target_t;
endpackage

// ### inc/flash_map_if.sv
// interface joining the cpu side and the flash control end
// assumes: one clock, cpu transfers of one cycle
`timescale 1ns/100ps
interface flash_map_if;
  logic        wr;         // register write strobe
  logic        rd;         // register read strobe
  logic [15:0] addr;       // register address
  logic [7:0]  wdata;      // write data
  logic [7:0]  rdata;      // read data, valid cycle after rd
  logic        fetch_ram;  // current instruction came from ram
  logic        irq;        // interrupt taken, one-cycle pulse
  modport device (input wr, rd, addr, wdata, fetch_ram, irq, output rdata);
  modport cpu (output wr, rd, addr, wdata, fetch_ram, irq, input rdata);
endinterface

// ### verilog/flash_cpu_port.sv
// cpu-side end: turns user requests into register transfers
// assumes: user holds req_i for one cycle; one request at a time
`include "flash_map_consts.svh"
`timescale 1ns/100ps
module flash_cpu_port (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        req_i,
  input  wire logic        req_write_i,
  input  wire logic [15:0] req_addr_i,
  input  wire logic [7:0]  req_wdata_i,
  input  wire logic        req_from_ram_i,
  input  wire logic        irq_i,
  output logic             rsp_valid_o,
  output logic [7:0]       rsp_rdata_o,
  flash_map_if.cpu         bus
);
  logic       rd_pend;
  logic       next_rd_pend;
  logic       next_valid;
  logic [7:0] next_rdata;
  logic       next_wr;
  logic       next_rd;
  logic [15:0] next_addr;
  logic [7:0] next_wdata;
  logic       next_fram;
  logic       next_irq;

  always_comb begin
    next_wr    = req_i & req_write_i;
    next_rd    = req_i & ~req_write_i;
    next_addr  = req_i ? req_addr_i : bus.addr;
    next_wdata = req_i ? req_wdata_i : bus.wdata;
    next_fram  = req_from_ram_i;
    next_irq   = irq_i;
    next_rd_pend = bus.rd;
    next_valid = rd_pend | bus.wr;
    next_rdata = rd_pend ? bus.rdata : rsp_rdata_o;
  end

  // register everything so the link is flop-driven
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      bus.wr        <= 1'b0;
      bus.rd        <= 1'b0;
      bus.addr      <= 16'h0000;
      bus.wdata     <= 8'h00;
      bus.fetch_ram <= 1'b0;
      bus.irq       <= 1'b0;
      rd_pend       <= 1'b0;
      rsp_valid_o   <= 1'b0;
      rsp_rdata_o   <= 8'h00;
    end else begin
      bus.wr        <= next_wr;
      bus.rd        <= next_rd;
      bus.addr      <= next_addr;
      bus.wdata     <= next_wdata;
      bus.fetch_ram <= next_fram;
      bus.irq       <= next_irq;
      rd_pend       <= next_rd_pend;
      rsp_valid_o   <= next_valid;
      rsp_rdata_o   <= next_rdata;
    end
  end
endmodule

// ### verilog/flash_map_protect_control.sv
// flash control end: protect gating, boot rom and ram overlay,
// standby bit and serial prom port input gating
// assumes: cpu end drives the interface; mode strap stable after reset
//
// Functional notes
// - 101 then commit key enables commands
// - 010 then commit key disables commands
// - commands ignored while disabled
// - reset leaves commands disabled
// - running sequence not aborted by protect
// - flash commands only via data window
// - area 10 maps code window onto data; here the area bits are only stored and read back
// - area 00 restores standard mapping
// - both windows hit same flash location
// - software erases before rewriting data
// - ram remap plus 0xD4 maps ram
// - prom mode always maps ram in code
// - boot show overlays boot rom region
// - prom mode boot rom fixed, reads one
// - sleep bit writable only from ram
// - flash touch while sleeping resets
// - flash vectors clear sleep bit on interrupt
// - ram vectors keep sleep bit
// - prom mode port inputs off after reset
// - port enable bits open gated inputs
// - mcu mode ignores port control
// - shadow applied only on commit key
// - monitor flag only when 101 effective
`include "flash_map_consts.svh"
`timescale 1ns/100ps
module flash_map_protect_control (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        prom_mode_i,
  input  wire logic        mem_valid_i,
  input  wire logic        mem_code_i,
  input  wire logic        mem_write_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        cmd_busy_i,
  flash_map_if.device      bus,
  output logic [1:0]       code_target_o,
  output logic [1:0]       data_target_o,
  output logic [15:0]      flash_addr_o,
  output logic             flash_cmd_o,
  output logic             cmd_enable_o,
  output logic             sleep_reset_o,
  output logic             serial_clk_gate_o,
  output logic             other_port_gate_o
);
  // ****************************************
  // state
  // ****************************************
  logic [7:0] flash_ctrl_shadow;
  logic [7:0] active;
  logic       system_ctrl_three;
  logic       vector_in_ram;
  logic       ram_remap_select;
  logic       ram_vec_active;
  logic       flash_sleep_bit;
  logic [1:0] prom_port_input_ctrl;
  logic       prom_q;
  logic [7:0] next_shadow;
  logic [7:0] next_active;
  logic       next_sys3;
  logic       next_vec;
  logic       next_remap;
  logic       next_vec_act;
  logic       next_sleep;
  logic [1:0] next_port;
  logic [7:0] next_rdata;
  logic       protect_monitor_flag;
  logic       boot_show;
  logic       in_flash;
  logic       in_boot_d;
  logic       in_boot_c;
  flash_map_pkg::target_t next_ct;
  flash_map_pkg::target_t next_dt;
  logic [15:0] next_faddr;
  logic        next_cmd;
  logic        next_srst;
  logic        next_sgate;
  logic        next_ogate;

  // ****************************************
  // register writes
  // ****************************************
  always_comb begin
    next_shadow  = flash_ctrl_shadow;
    next_active  = active;
    next_sys3    = system_ctrl_three;
    next_vec     = vector_in_ram;
    next_remap   = ram_remap_select;
    next_vec_act = ram_vec_active;
    next_sleep   = flash_sleep_bit;
    next_port    = prom_port_input_ctrl;
    if (bus.wr) begin
      case (bus.addr)
        `ADDR_CTRL_SHADOW: next_shadow = bus.wdata;
        `ADDR_CTRL_COMMIT: if (bus.wdata == `COMMIT_KEY) begin
          next_active = flash_ctrl_shadow;
        end
        `ADDR_SLEEP_REG: if (bus.fetch_ram) begin
          next_sleep = bus.wdata[0];
        end
        `ADDR_PROM_PORT: if (prom_q) begin
          next_port = bus.wdata[1:0];
        end
        `ADDR_SYS_CTRL_3: begin
          next_sys3 = bus.wdata[`RAM_REMAP_BIT];
          next_vec  = bus.wdata[`VECTOR_RAM_BIT];
        end
        `ADDR_SYS_COMMIT: if (bus.wdata == `SYS_COMMIT_KEY) begin
          next_remap   = system_ctrl_three;
          next_vec_act = vector_in_ram;
        end
        default: ;
      endcase
    end
    // interrupt with flash vectors wakes flash
    if (bus.irq && !ram_vec_active) begin
      next_sleep = 1'b0;
    end
  end

  // ****************************************
  // read mux and monitor
  // ****************************************
  // committed code drives enable
  // flag only for committed enable code
  assign protect_monitor_flag =
    (active[`PROTECT_MSB:`PROTECT_LSB] == `PROTECT_ENABLE);
  assign boot_show = prom_q | active[`BOOT_SHOW_BIT];

  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `ADDR_CTRL_SHADOW: next_rdata = flash_ctrl_shadow;
        // monitor shares the commit address; shown boot bit replaces the raw one
        `ADDR_CTRL_COMMIT: next_rdata = {3'b000, protect_monitor_flag, boot_show,
                                         active[2:0]};
        `ADDR_PROM_PORT:   next_rdata = prom_q ? {6'b000000, prom_port_input_ctrl} | 8'h80
                                               : 8'h00;
        `ADDR_SYS_CTRL_3:  next_rdata = {6'b000000, vector_in_ram, system_ctrl_three};
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // address resolution
  // ****************************************
  // both windows resolve to one location
  assign in_flash  = mem_addr_i >= `FLASH_LO;
  assign in_boot_d = (mem_addr_i >= `BOOT_LO) && (mem_addr_i <= `BOOT_DATA_HI);
  assign in_boot_c = prom_q ? ((mem_addr_i >= `BOOT_LO) && (mem_addr_i <= `BOOT_CODE_HI_PROM))
                            : in_boot_d;

  always_comb begin
    next_ct = flash_map_pkg::TGT_OTHER;
    next_dt = flash_map_pkg::TGT_OTHER;
    if (boot_show && in_boot_c) begin
      next_ct = flash_map_pkg::TGT_BOOT;
    end else if ((prom_q || ram_remap_select) && !in_flash) begin
      next_ct = flash_map_pkg::TGT_RAM;
    end else if (in_flash) begin
      next_ct = flash_map_pkg::TGT_FLASH;
    end
    if (boot_show && in_boot_d) begin
      next_dt = flash_map_pkg::TGT_BOOT;
    end else if (in_flash) begin
      // data window standard view in every area setting
      next_dt = flash_map_pkg::TGT_FLASH;
    end
    next_faddr = mem_addr_i;
    // gated new writes; busy sequence runs on
    next_cmd = mem_valid_i && mem_write_i && !mem_code_i && in_flash
               && protect_monitor_flag;
    next_srst = mem_valid_i && in_flash && flash_sleep_bit && !cmd_busy_i | 
                (mem_valid_i && in_flash && flash_sleep_bit);
    // port gating; the raw strap keeps the gates
    // shut in the cycle before prom_q has caught it after reset
    next_sgate = (!prom_q && !prom_mode_i) | prom_port_input_ctrl[`SERIAL_CLK_EN_BIT];
    next_ogate = (!prom_q && !prom_mode_i) | prom_port_input_ctrl[`OTHER_PORT_EN_BIT];
  end

  // ****************************************
  // registers
  // ****************************************
  // reset code disables commands
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      flash_ctrl_shadow    <= `SHADOW_RESET;
      active               <= `SHADOW_RESET;
      system_ctrl_three    <= 1'b0;
      vector_in_ram        <= 1'b0;
      ram_remap_select     <= 1'b0;
      ram_vec_active       <= 1'b0;
      flash_sleep_bit      <= 1'b0;
      prom_port_input_ctrl <= 2'b00;
      prom_q               <= 1'b0;
      bus.rdata            <= 8'h00;
      code_target_o        <= 2'b10;
      data_target_o        <= 2'b10;
      flash_addr_o         <= 16'h0000;
      flash_cmd_o          <= 1'b0;
      cmd_enable_o         <= 1'b0;
      sleep_reset_o        <= 1'b0;
      serial_clk_gate_o    <= 1'b0;
      other_port_gate_o    <= 1'b0;
    end else begin
      flash_ctrl_shadow    <= next_shadow;
      active               <= next_active;
      system_ctrl_three    <= next_sys3;
      vector_in_ram        <= next_vec;
      ram_remap_select     <= next_remap;
      ram_vec_active       <= next_vec_act;
      flash_sleep_bit      <= next_sleep;
      prom_port_input_ctrl <= next_port;
      prom_q               <= prom_mode_i;  // strap caught after release
      bus.rdata            <= next_rdata;
      code_target_o        <= next_ct;
      data_target_o        <= next_dt;
      flash_addr_o         <= next_faddr;
      flash_cmd_o          <= next_cmd;
      cmd_enable_o         <= protect_monitor_flag;
      sleep_reset_o        <= next_srst;
      serial_clk_gate_o    <= next_sgate;
      other_port_gate_o    <= next_ogate;
    end
  end
endmodule

// ### verif/flash_map_monitor.sv
// checker for the control link and the flash control outputs
// assumes: fed from the interface and the control end in the bench top
`include "flash_map_consts.svh"
`timescale 1ns/100ps
module flash_map_monitor (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        wr,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        prom_mode_i,
  input  wire logic        mem_valid_i,
  input  wire logic        mem_code_i,
  input  wire logic        mem_write_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        flash_cmd_o,
  input  wire logic        cmd_enable_o,
  input  wire logic        sleep_reset_o,
  input  wire logic [1:0]  code_target_o
);
  // ********************
  // shadow protect code
  // ********************
  logic [2:0] prot;
  logic [2:0] next_prot;
  // mirrors shadow writes so that a commit can be judged
  always_comb begin
    next_prot = prot;
    if (wr && addr == `ADDR_CTRL_SHADOW) next_prot = wdata[6:4];
  end
  // reset puts the disabling code back
  always_ff @(posedge clk_sys_i) begin
    prot <= nrst_i ? next_prot : 3'b010;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // key write on the bus
  sequence s_commit;
    wr && addr == `ADDR_CTRL_COMMIT && wdata == `COMMIT_KEY;
  endsequence
  chk_reset_off: assert property (disable iff (1'b0) !nrst_i |=> !cmd_enable_o)
    else $error("commands enabled after reset");
  chk_commit_on: assert property (s_commit ##0 prot == 3'b101 |-> ##2 cmd_enable_o)
    else $error("enable code commit ignored");
  chk_commit_off: assert property (s_commit ##0 prot == 3'b010 |-> ##2 !cmd_enable_o)
    else $error("disable code commit ignored");
  chk_bad_key: assert property (wr && addr == `ADDR_CTRL_COMMIT && wdata != `COMMIT_KEY
    |-> ##2 $stable(cmd_enable_o)) else $error("wrong key changed state");
  chk_cmd_gate: assert property (flash_cmd_o |-> $past(cmd_enable_o) && $past(mem_valid_i)
    && !$past(mem_code_i)) else $error("command passed while gated");
  chk_cmd_issue: assert property (mem_valid_i && mem_write_i && !mem_code_i &&
    mem_addr_i[15] && cmd_enable_o |=> flash_cmd_o) else $error("command write lost");
  chk_sleep_cause: assert property ($rose(sleep_reset_o) |-> $past(mem_valid_i))
    else $error("standby reset without access");
  chk_prom_boot: assert property (prom_mode_i && $past(prom_mode_i) && $past(nrst_i) &&
    mem_valid_i && mem_addr_i inside {[`BOOT_LO:`BOOT_CODE_HI_PROM]}
    |=> code_target_o == flash_map_pkg::TGT_BOOT) else $error("boot rom not in code area");
endmodule

// ### verif/flash_map_protect_control_test.sv
// self-checking bench: cpu port and control end joined by the interface
// assumes: constants header, package, interface and both ends compiled
`include "flash_map_consts.svh"
`timescale 1ns/100ps
module flash_map_protect_control_test;
  logic        clk_sys_i, nrst_i, req_i, req_write_i, req_from_ram_i, irq_i;
  logic        prom_mode_i, mem_valid_i, mem_code_i, mem_write_i, cmd_busy_i;
  logic [15:0] req_addr_i, mem_addr_i, a, flash_addr_o;
  logic [7:0]  req_wdata_i, rsp_rdata_o, k, rv;
  logic [1:0]  code_target_o, data_target_o, gp;
  logic        rsp_valid_o, flash_cmd_o, cmd_enable_o, sleep_reset_o;
  logic        serial_clk_gate_o, other_port_gate_o, en, c, w;
  int          fails, comparisons;
  flash_map_if link ();
  flash_cpu_port flash_cpu_port_i (.clk_sys_i, .nrst_i, .req_i, .req_write_i, .req_addr_i,
    .req_wdata_i, .req_from_ram_i, .irq_i, .rsp_valid_o, .rsp_rdata_o, .bus(link.cpu));
  flash_map_protect_control flash_map_protect_control_i (.clk_sys_i, .nrst_i, .prom_mode_i,
    .mem_valid_i, .mem_code_i, .mem_write_i, .mem_addr_i, .cmd_busy_i, .bus(link.device),
    .code_target_o, .data_target_o, .flash_addr_o, .flash_cmd_o, .cmd_enable_o,
    .sleep_reset_o, .serial_clk_gate_o, .other_port_gate_o);
  flash_map_monitor flash_map_monitor_i (.clk_sys_i, .nrst_i, .wr(link.wr), .addr(link.addr),
    .wdata(link.wdata), .prom_mode_i, .mem_valid_i, .mem_code_i, .mem_write_i, .mem_addr_i,
    .flash_cmd_o, .cmd_enable_o, .sleep_reset_o, .code_target_o);
  // *******************
  // clock and helpers
  // *******************
  always #5 clk_sys_i = ~clk_sys_i;
  // command reaches flash only as an enabled data window write
  function automatic logic exp_cmd(logic e, logic cd, logic wt, logic [15:0] ad);
    return e & wt & ~cd & ad[15];
  endfunction
  // monitor view: flag, shown boot bit, then the low shadow fields
  function automatic logic [7:0] exp_mon(logic [7:0] v, logic prom);
    return {3'b000, v[`PROTECT_MSB:`PROTECT_LSB] == `PROTECT_ENABLE,
            v[`BOOT_SHOW_BIT] | prom, v[2:0]};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one register write; the answer is awaited under a bound
  task automatic reg_wr(input logic [15:0] ad, input logic [7:0] d, input logic ram);
    int n;
    @(posedge clk_sys_i);
    req_i <= 1'b1;
    req_write_i <= 1'b1;
    req_addr_i <= ad;
    req_wdata_i <= d;
    req_from_ram_i <= ram;
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    #1;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 8) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    check(n < 8, 1'b1, "write answer");
    repeat (2) @(posedge clk_sys_i);
  endtask
  // one register read; data taken once the answer stands
  task automatic reg_rd(input logic [15:0] ad, output logic [7:0] d);
    int n;
    @(posedge clk_sys_i);
    req_i <= 1'b1;
    req_write_i <= 1'b0;
    req_addr_i <= ad;
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    #1;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 8) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    d = rsp_rdata_o;
    check(n < 8, 1'b1, "read answer");
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic commit(input logic [7:0] v);
    reg_wr(`ADDR_CTRL_SHADOW, v, 1'b0);
    reg_wr(`ADDR_CTRL_COMMIT, `COMMIT_KEY, 1'b0);
  endtask
  // one-cycle cpu access, outputs sampled once registered
  task automatic mem(input logic cd, input logic wt, input logic [15:0] ad);
    @(posedge clk_sys_i);
    mem_valid_i <= 1'b1;
    mem_code_i <= cd;
    mem_write_i <= wt;
    mem_addr_i <= ad;
    @(posedge clk_sys_i);
    mem_valid_i <= 1'b0;
    #1;
  endtask
  task automatic pulse_irq();
    @(posedge clk_sys_i);
    irq_i <= 1'b1;
    @(posedge clk_sys_i);
    irq_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask
  task automatic do_reset();
    nrst_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    gp = {serial_clk_gate_o, other_port_gate_o};  // gates in the first cycle after release
    @(posedge clk_sys_i);
    #1;
  endtask
  // hang guard, far beyond the few hundred cycles of the run
  initial begin
    #100000;
    fails++;
    $display("Error %0t: run timed out", $time);
    wrap_up();
  end
  // *******************
  // main sequence
  // *******************
  initial begin
    {clk_sys_i, req_i, req_write_i, req_from_ram_i, irq_i, cmd_busy_i} = '0;
    {prom_mode_i, mem_valid_i, mem_code_i, mem_write_i} = '0;
    {req_addr_i, mem_addr_i, req_wdata_i, nrst_i} = '0;
    void'($urandom(41));
    do_reset();
    check(cmd_enable_o, 1'b0, "enable after reset");
    reg_wr(`ADDR_CTRL_SHADOW, 8'h50, 1'b0);
    k = 8'($urandom);
    if (k == `COMMIT_KEY) k = 8'h00;
    reg_wr(`ADDR_CTRL_COMMIT, k, 1'b0);
    check(cmd_enable_o, 1'b0, "enable before key");
    reg_rd(`ADDR_CTRL_COMMIT, rv);
    check(rv, exp_mon(`SHADOW_RESET, 1'b0), "monitor before key");
    reg_wr(`ADDR_CTRL_COMMIT, `COMMIT_KEY, 1'b0);
    check(cmd_enable_o, 1'b1, "enable after key");
    reg_rd(`ADDR_CTRL_COMMIT, rv);
    check(rv, exp_mon(8'h50, 1'b0), "monitor enabled");
    for (int i = 0; i < 16; i++) begin
      if (i == 8) commit(8'h20);
      en = i < 8;
      a = i == 0 ? 16'h8000 : i == 1 ? 16'h7FFF : 16'($urandom);
      c = i >= 2 && 1'($urandom);
      w = i < 2 || 1'($urandom);
      mem(c, w, a);
      check(flash_cmd_o, exp_cmd(en, c, w, a), "flash command");
      check(flash_addr_o, a, "flash address");
    end
    commit(8'h28);
    mem(1'b0, 1'b0, `BOOT_LO);
    check(data_target_o, flash_map_pkg::TGT_BOOT, "boot shown low");
    mem(1'b1, 1'b0, `BOOT_DATA_HI);
    check(code_target_o, flash_map_pkg::TGT_BOOT, "boot shown high");
    mem(1'b0, 1'b0, 16'h1800);
    check(data_target_o == flash_map_pkg::TGT_BOOT, 1'b0, "boot end");
    commit(8'h24);
    mem(1'b1, 1'b0, 16'h9000);
    check(code_target_o, flash_map_pkg::TGT_FLASH, "area remap");
    reg_rd(`ADDR_CTRL_COMMIT, rv);
    check(rv, exp_mon(8'h24, 1'b0), "area committed");
    reg_wr(`ADDR_SLEEP_REG, 8'h01, 1'b0);
    mem(1'b0, 1'b0, `FLASH_LO);
    check(sleep_reset_o, 1'b0, "standby from flash");
    reg_wr(`ADDR_SLEEP_REG, 8'h01, 1'b1);
    mem(1'b0, 1'b0, `FLASH_LO);
    check(sleep_reset_o, 1'b1, "standby access");
    pulse_irq();
    mem(1'b0, 1'b0, `FLASH_LO);
    check(sleep_reset_o, 1'b0, "flash vector clears");
    mem(1'b1, 1'b0, 16'h0400);
    check(code_target_o, flash_map_pkg::TGT_OTHER, "ram hidden");
    reg_wr(`ADDR_SYS_CTRL_3, 8'h03, 1'b0);
    reg_wr(`ADDR_SYS_COMMIT, `SYS_COMMIT_KEY, 1'b0);
    mem(1'b1, 1'b0, 16'h0400);
    check(code_target_o, flash_map_pkg::TGT_RAM, "ram in code area");
    reg_wr(`ADDR_SLEEP_REG, 8'h01, 1'b1);
    pulse_irq();
    mem(1'b0, 1'b0, `FLASH_LO);
    check(sleep_reset_o, 1'b1, "ram vector keeps");
    reg_wr(`ADDR_SLEEP_REG, 8'h00, 1'b1);
    prom_mode_i <= 1'b1;
    do_reset();
    check(gp, 2'b00, "prom gates at release");
    check({serial_clk_gate_o, other_port_gate_o}, 2'b00, "prom gates shut");
    commit(8'h20);
    reg_rd(`ADDR_CTRL_COMMIT, rv);
    check(rv, exp_mon(8'h20, 1'b1), "prom boot bit reads one");
    mem(1'b1, 1'b0, 16'h1C00);
    check(code_target_o, flash_map_pkg::TGT_BOOT, "prom code boot");
    check(data_target_o == flash_map_pkg::TGT_BOOT, 1'b0, "prom data boot");
    mem(1'b1, 1'b0, 16'h0400);
    check(code_target_o, flash_map_pkg::TGT_RAM, "prom ram in code");
    reg_wr(`ADDR_PROM_PORT, 8'h02, 1'b0);
    check({serial_clk_gate_o, other_port_gate_o}, 2'b10, "serial clock gate");
    reg_wr(`ADDR_PROM_PORT, 8'h01, 1'b0);
    check({serial_clk_gate_o, other_port_gate_o}, 2'b01, "other port gate");
    reg_rd(`ADDR_PROM_PORT, rv);
    check(rv, `PROM_PORT_RESET | 8'h01, "prom port readback");
    prom_mode_i <= 1'b0;
    do_reset();
    check(gp, 2'b11, "mcu ports open");
    reg_wr(`ADDR_PROM_PORT, 8'h03, 1'b0);
    check({serial_clk_gate_o, other_port_gate_o}, 2'b11, "mcu port control");
    reg_rd(`ADDR_PROM_PORT, rv);
    check(rv, 8'h00, "mcu port reads zero");
    wrap_up();
  end
endmodule
